/* File: hw/pwrmon_map.svh */
// Register map, field positions and timing counts of the power monitor
`ifndef PWRMON_MAP_SVH
`define PWRMON_MAP_SVH

// =====================================================================
// Register offsets (4-bit register address)
`define PWRMON_ADDR_TRIM 4'h7
`define PWRMON_ADDR_CTRL1 4'hE
`define PWRMON_ADDR_PSC 4'hF

// =====================================================================
// Field positions in power_status_control
`define PWRMON_PSC_THR 7
`define PWRMON_PSC_VDET 6
`define PWRMON_PSC_OSC 5
`define PWRMON_PSC_PWRON 4
`define PWRMON_PSC_SCR 3
`define PWRMON_PSC_PER 2
`define PWRMON_PSC_WK 1
`define PWRMON_PSC_DY 0

// =====================================================================
// Reset values
`define PWRMON_RST_BYTE 8'h00
`define PWRMON_RST_PSC 8'h10

// =====================================================================
// Timing: core clock period, sampling window, one second, osc tick
`define PWRMON_CLK_NS 40
`define PWRMON_WIN_NS 7800000
`define PWRMON_SEC_NS 1000000000
`define PWRMON_OSC_HZ 32768
`define PWRMON_WIN_CYC (`PWRMON_WIN_NS / `PWRMON_CLK_NS)
`define PWRMON_SEC_CYC (`PWRMON_SEC_NS / `PWRMON_CLK_NS)
`define PWRMON_OSC_CYC (`PWRMON_SEC_CYC / `PWRMON_OSC_HZ)
`define PWRMON_REL_TICKS 16384

`endif

/* File: hw/pwrmon_pkg.sv */
// Types shared by the power monitor design files
package pwrmon_pkg;

  // ===================================================================
  // Status and control register 0xF image
  typedef struct packed {
    logic vdd_threshold_select;  // Core supply threshold select
    logic vdet;                  // Core supply low flag
    logic osc_running_flag;      // Oscillator running, low on halt
    logic power_on_flag;         // Power-on flag
    logic scratch1;  // Scratch bit
    logic per_flag;  // Periodic flag
    logic wk_flag;   // Weekly alarm flag
    logic dy_flag;   // Daily alarm flag
  } pwrmon_psc_t;

  // ===================================================================
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pwrmon_req_t;

  // Host reset release sequence
  typedef enum logic [1:0] {
    RST_HOLD,
    RST_WAIT,
    RST_OFF
  } pwrmon_rst_t;

endpackage : pwrmon_pkg

/* File: hw/pwrmon_tick.sv */
// Clock-enable divider producing a one-cycle tick
`timescale 1ns/10ps
`default_nettype none

module pwrmon_tick #(
  parameter int unsigned DIV = 2
) (
  input wire logic core_clk_i,  // System clock
  input wire logic sys_rst_i,   // Sync reset, high
  input wire logic run_i,       // Divider runs while high
  output logic tick_o           // One-cycle tick
);

  logic [24:0] cnt_ff;
  logic tick_ff;
  wire last = (cnt_ff == 25'(DIV - 1));

  // =====================================================================
  // Counter; stopped counter restarts a full period later
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_ff <= 25'h0000000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= last ? 25'h0000000 : cnt_ff + 25'h0000001;
      tick_ff <= last;
    end
  end

  assign tick_o = tick_ff;

endmodule // pwrmon_tick

`default_nettype wire

/* File: hw/pwrmon_top.sv */
// Power-on, oscillator-halt and supply monitor with status register
//
// Summary of operation
// (R1) Power-up from zero: power-on one, VDET zero
// (R2) Power-on, VDET take zero; running flag both
// (R3) Flags high active; running flag low on halt
// (R4) Power-on flag set clears trim, control, flags
// (R5) Halt from sag: running flag cleared, VDET set
// (R6) Core supply sampled 7.8 ms each second
// (R7) Threshold select: zero 2.1 V, one 1.35 V
// (R8) VDET set stops sampling until cleared
// (R9) Monitor result held in bit D6, address Fh
// (R10) Same level falling and rising, no hysteresis
// (R11) Host clears VDET once after seconds write
// (R12) Main supply monitor runs continuously
// (R13) Main low: switch to backup, reset low
// (R14) Main high: main switch, reset after delay
// (R15) Halted oscillator: delay starts at oscillation
// (R16) Release delay is parameterised oscillator tick count
`timescale 1ns/10ps
`default_nettype none

`include "pwrmon_map.svh"

module pwrmon_top
  import pwrmon_pkg::*;
#(
  parameter int unsigned SEC_CYC = `PWRMON_SEC_CYC,
  parameter int unsigned WIN_CYC = `PWRMON_WIN_CYC,
  parameter int unsigned REL_TICKS = `PWRMON_REL_TICKS
) (
  input wire logic core_clk_i,          // 25 MHz clock
  input wire logic sys_rst_i,           // Sync reset, high
  input wire logic por_i,               // Core supply rose from zero
  input wire logic osc_run_i,           // Oscillator seen running
  input wire logic vdd_low_i,           // Core supply below threshold
  input wire logic vcc_low_i,           // Main supply below detect level
  input wire logic [2:0] flag_set_i,    // Periodic, weekly, daily events
  input wire pwrmon_req_t req_i,        // Register access
  output logic [7:0] reg_rdata_o,       // Read data, one cycle later
  output logic sample_en_o,             // Core comparator window
  output logic vdd_thresh_sel_o,        // Threshold select to comparator
  output logic main_sw_o,               // Main supply switch closed
  output logic backup_sw_o,             // Backup supply switch closed
  output logic host_reset_n_o           // Host reset, active low
);

  // =====================================================================
  // Registers
  pwrmon_psc_t psc_ff, nxt_psc;
  logic [7:0] trim_ff, nxt_trim;
  logic [7:0] ctrl1_ff, nxt_ctrl1;
  logic [7:0] rdata_ff;
  logic osc_q_ff;
  logic win_ff;
  logic [17:0] win_cnt_ff;
  logic main_sw_ff, backup_sw_ff, host_rst_n_ff;
  pwrmon_rst_t rst_st_ff, nxt_rst_st;
  logic [15:0] rel_cnt_ff;
  logic sec_tick, osc_tick;

  // One-bit masked write: bit kept unless a zero is written
  // Shared by every flag that software may only clear
  function automatic logic clr_only(input logic cur, input logic hit,
                                    input logic wbit);
    clr_only = cur & ~(hit & ~wbit);
  endfunction

  // =====================================================================
  // Address decode
  // Only three registers live here; other offsets decode to nothing
  wire wr_psc = req_i.wr && (req_i.addr == `PWRMON_ADDR_PSC);
  wire wr_trim = req_i.wr && (req_i.addr == `PWRMON_ADDR_TRIM);
  wire wr_ctrl1 = req_i.wr && (req_i.addr == `PWRMON_ADDR_CTRL1);
  wire [7:0] wd = req_i.wdata;

  // Read selection; unmapped addresses read zero
  wire [7:0] rd_sel =
    (req_i.addr == `PWRMON_ADDR_PSC) ? psc_ff :
    (req_i.addr == `PWRMON_ADDR_TRIM) ? trim_ff :
    (req_i.addr == `PWRMON_ADDR_CTRL1) ? ctrl1_ff : 8'h00;

  // =====================================================================
  // Monitor events
  wire osc_stop = osc_q_ff & ~osc_run_i;                      // R3
  wire sag_stop = osc_stop & vdd_low_i;                       // R5
  // Single comparator level: release equals detection
  wire win_hit = win_ff & vdd_low_i;                          // R10
  wire vdet_set = win_hit | sag_stop;                         // R9

  // =====================================================================
  // Dividers: one second and oscillator-rate ticks
  // The second divider never stops, so windows stay a second apart
  pwrmon_tick #(.DIV(SEC_CYC)) u_sec (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(1'b1),
    .tick_o(sec_tick)
  );

  // Runs only while oscillating, so a halt freezes release timing
  pwrmon_tick #(.DIV(`PWRMON_OSC_CYC)) u_osc (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(osc_run_i),
    .tick_o(osc_tick)
  );

  // A tick already in flight when the oscillator halts is dropped, so
  // the release delay never advances while the crystal is stopped
  wire rel_step = osc_tick & osc_run_i;                       // R15

  // =====================================================================
  // Status register next value; hardware sets win over software clears, power-up beats both
  always_comb begin
    nxt_psc = psc_ff;
    nxt_trim = wr_trim ? wd : trim_ff;
    nxt_ctrl1 = wr_ctrl1 ? wd : ctrl1_ff;
    // Plain read-write bits take the written value
    if (wr_psc) begin
      nxt_psc.vdd_threshold_select = wd[`PWRMON_PSC_THR];           // R7
      nxt_psc.osc_running_flag = wd[`PWRMON_PSC_OSC];               // R2
      nxt_psc.scratch1 = wd[`PWRMON_PSC_SCR];
    end
    // Zero-only flags: a written one leaves the bit alone
    nxt_psc.vdet = clr_only(psc_ff.vdet, wr_psc,
                            wd[`PWRMON_PSC_VDET]) | vdet_set;       // R2
    nxt_psc.power_on_flag = clr_only(psc_ff.power_on_flag, wr_psc,
                                     wd[`PWRMON_PSC_PWRON]);        // R2
    nxt_psc.per_flag = clr_only(psc_ff.per_flag, wr_psc,
                                wd[`PWRMON_PSC_PER]) | flag_set_i[2];
    nxt_psc.wk_flag = clr_only(psc_ff.wk_flag, wr_psc,
                               wd[`PWRMON_PSC_WK]) | flag_set_i[1];
    nxt_psc.dy_flag = clr_only(psc_ff.dy_flag, wr_psc,
                               wd[`PWRMON_PSC_DY]) | flag_set_i[0];
    // A halt beats a software write of one in the same cycle
    if (osc_stop) begin
      nxt_psc.osc_running_flag = 1'b0;                              // R3
    end
    // Power-up from zero wipes trim, control and status fields, sets the power-on flag and keeps the running flag unless a halt lands
    if (por_i) begin
      nxt_psc = pwrmon_psc_t'(`PWRMON_RST_PSC);                     // R4
      // Running flag is undefined at power-up: kept, but halts still land
      nxt_psc.osc_running_flag = psc_ff.osc_running_flag & ~osc_stop;
      nxt_trim = `PWRMON_RST_BYTE;                                // R4
      nxt_ctrl1 = `PWRMON_RST_BYTE;                               // R4
    end
  end

  // Register file update; reset stands for power-up from zero
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      psc_ff <= pwrmon_psc_t'(`PWRMON_RST_PSC);                   // R1
      trim_ff <= `PWRMON_RST_BYTE;
      ctrl1_ff <= `PWRMON_RST_BYTE;
      rdata_ff <= 8'h00;
    end else begin
      psc_ff <= nxt_psc;
      trim_ff <= nxt_trim;
      ctrl1_ff <= nxt_ctrl1;
      rdata_ff <= req_i.rd ? rd_sel : rdata_ff;
    end
  end

  // =====================================================================
  // Core supply sampling: one short window per second saves current
  // The window also closes one cycle after the flag sets
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      win_ff <= 1'b0;
      win_cnt_ff <= 18'h00000;
    end else if (win_ff) begin
      win_cnt_ff <= win_cnt_ff + 18'h00001;
      if (win_cnt_ff == 18'(WIN_CYC - 1) || psc_ff.vdet) begin    // R8
        win_ff <= 1'b0;
      end
    end else if (sec_tick && !psc_ff.vdet) begin                  // R6
      win_ff <= 1'b1;
      win_cnt_ff <= 18'h00000;
    end
  end

  // Oscillator level delayed for halt detection; a reset value of zero
  // can only make a rising edge, so no false halt follows reset
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      osc_q_ff <= 1'b0;
    end else begin
      osc_q_ff <= osc_run_i;
    end
  end

  // =====================================================================
  // Main supply monitor, evaluated every cycle
  // Hold while low, wait out the delay, then release; a new drop from
  // any state returns to hold at once
  always_comb begin
    nxt_rst_st = rst_st_ff;
    case (rst_st_ff)
      RST_HOLD: nxt_rst_st = vcc_low_i ? RST_HOLD : RST_WAIT;     // R14
      RST_WAIT: begin
        if (vcc_low_i) begin
          nxt_rst_st = RST_HOLD;                                  // R13
        end else if (rel_step && rel_cnt_ff == 16'(REL_TICKS - 1)) begin
          nxt_rst_st = RST_OFF;                                   // R16
        end
      end
      RST_OFF: nxt_rst_st = vcc_low_i ? RST_HOLD : RST_OFF;       // R13
      default: nxt_rst_st = RST_HOLD;
    endcase
  end

  // Switches and reset output follow the continuous comparator
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rst_st_ff <= RST_HOLD;
      rel_cnt_ff <= 16'h0000;
      main_sw_ff <= 1'b0;
      backup_sw_ff <= 1'b1;
      host_rst_n_ff <= 1'b0;
    end else begin
      rst_st_ff <= nxt_rst_st;
      if (rst_st_ff != RST_WAIT) begin
        rel_cnt_ff <= 16'h0000;
      end else if (rel_step) begin
        rel_cnt_ff <= rel_cnt_ff + 16'h0001;                      // R15
      end
      main_sw_ff <= ~vcc_low_i;                                   // R12
      backup_sw_ff <= vcc_low_i;                                  // R13
      host_rst_n_ff <= (nxt_rst_st == RST_OFF);                   // R14
    end
  end

  // =====================================================================
  // Outputs
  // Every output is a flop, no logic between register and pin
  assign reg_rdata_o = rdata_ff;
  assign sample_en_o = win_ff;
  assign vdd_thresh_sel_o = psc_ff.vdd_threshold_select;          // R7
  assign main_sw_o = main_sw_ff;
  assign backup_sw_o = backup_sw_ff;
  assign host_reset_n_o = host_rst_n_ff;

  // =====================================================================
  // Assertions
  // Checks cover the status flags, the sampling windows and the main
  // supply; covers mark the scenarios the bench must reach
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Status register flags
  a_reset_image: assert property ($fell(sys_rst_i) |-> // R1
    psc_ff == pwrmon_psc_t'(`PWRMON_RST_PSC) && !host_reset_n_o)
    else $error("reset image wrong");
  a_power_on_wipe: assert property (por_i |=> psc_ff.power_on_flag && // R4
    !psc_ff.vdet && !psc_ff.vdd_threshold_select && trim_ff == 8'h00 &&
    ctrl1_ff == 8'h00) else $error("power-on did not clear fields");
  a_power_on_no_set: assert property (!por_i && // R2
    !psc_ff.power_on_flag |=> !psc_ff.power_on_flag)
    else $error("power-on flag set by write");
  a_vdet_write0: assert property (wr_psc && !wd[6] && !vdet_set // R2
    |=> !psc_ff.vdet) else $error("flag not cleared by zero");
  a_vdet_keeps_one: assert property (psc_ff.vdet && !por_i && // R2
    !(wr_psc && !wd[`PWRMON_PSC_VDET]) |=> psc_ff.vdet)
    else $error("flag lost without a zero write");
  a_osc_halt_low: assert property (osc_stop |=> // R3
    !psc_ff.osc_running_flag) else $error("halt not recorded");
  a_sag_sets_vdet: assert property (sag_stop && !por_i |=> psc_ff.vdet) // R5
    else $error("sag halt not recorded");
  a_thr_follows: assert property (wr_psc && !por_i |=> // R7
    vdd_thresh_sel_o == $past(wd[`PWRMON_PSC_THR]))
    else $error("threshold select not written");

  // Core supply sampling windows
  a_vdet_only_sampled: assert property (!psc_ff.vdet && !win_hit && // R6
    !sag_stop |=> !psc_ff.vdet) else $error("flag set outside window");
  a_win_bounded: assert property (win_ff |-> // R6
    win_cnt_ff < 18'(WIN_CYC)) else $error("window longer than set");
  a_sample_stops: assert property (psc_ff.vdet && !win_ff |=> !win_ff) // R8
    else $error("sampling while flag set");
  a_win_start: assert property (sec_tick && !psc_ff.vdet && !win_ff // R6
    |=> win_ff) else $error("window did not open");

  // Main supply switches and host reset
  a_main_low: assert property (vcc_low_i |=> !host_reset_n_o && // R13
    backup_sw_o && !main_sw_o) else $error("main low not handled");
  a_main_high: assert property (!vcc_low_i |=> main_sw_o && !backup_sw_o) // R14
    else $error("main switch not closed");
  a_hold_no_release: assert property (rst_st_ff == RST_HOLD |=> // R14
    !host_reset_n_o) else $error("released straight from low supply");
  a_halt_holds: assert property (rst_st_ff == RST_WAIT && !osc_run_i // R15
    && !vcc_low_i |=> !host_reset_n_o) else $error("released while halted");

  // Main scenarios seen at least once
  c_release: cover property (!host_reset_n_o ##1 host_reset_n_o);
  c_vdet_hit: cover property (win_hit);
  c_sag_halt: cover property (sag_stop);
  c_power_on: cover property (por_i);
  c_halted_wait: cover property (rst_st_ff == RST_WAIT && !osc_run_i);

endmodule // pwrmon_top

`default_nettype wire

/* File: sim/pwrmon_host.sv */
// Host CPU model driving the register port of the power monitor
`timescale 1ns/10ps
`default_nettype none

module pwrmon_host
  import pwrmon_pkg::*;
(
  input wire logic core_clk_i,     // System clock
  input wire logic [7:0] rdata_i,  // Read data from device
  output var pwrmon_req_t req_o    // Register request
);
  // =====================================================================
  // Idle bus
  initial req_o = '{wr: 1'b0, rd: 1'b0, addr: 4'h0, wdata: 8'h00};

  // One access: held over one rising edge, then released with inverted
  // leftovers so a stale address or data word never looks valid
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk_i);
    req_o = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(negedge core_clk_i);
    q = rdata_i;
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // Clear the supply-low flag once, keeping the other writable bits
  task automatic clear_vdet(input logic [7:0] keep);
    logic [7:0] q;
    xfer(1'b1, 4'hF, keep & 8'hBF, q);
  endtask
endmodule // pwrmon_host

`default_nettype wire

/* File: sim/tb_power_osc_supply_monitor.sv */
// Self-checking bench for the power and supply monitor
`timescale 1ns/10ps
`default_nettype none

module tb_power_osc_supply_monitor;
  import pwrmon_pkg::*;
  localparam int REL = 4;
  localparam int OSC = 762;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic por_i = 1'b0;
  logic osc_run_i = 1'b1;
  logic vdd_low_i = 1'b0;
  logic vcc_low_i = 1'b0;
  logic [2:0] flag_set_i = 3'h0;
  pwrmon_req_t req;
  logic [7:0] rdata;
  logic sample_en, thr_sel, main_sw, backup_sw, rst_n;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] psc, d, e7, ee;

  // =====================================================================
  // Clock, device and host
  always #20 core_clk_i = ~core_clk_i;

  pwrmon_top #(.SEC_CYC(100), .WIN_CYC(10), .REL_TICKS(REL)) dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i),
    .osc_run_i(osc_run_i), .vdd_low_i(vdd_low_i), .vcc_low_i(vcc_low_i),
    .flag_set_i(flag_set_i), .req_i(req), .reg_rdata_o(rdata),
    .sample_en_o(sample_en), .vdd_thresh_sel_o(thr_sel),
    .main_sw_o(main_sw), .backup_sw_o(backup_sw),
    .host_reset_n_o(rst_n));

  pwrmon_host host (.core_clk_i(core_clk_i), .rdata_i(rdata), .req_o(req));

  // =====================================================================
  // Compare tasks and expectations
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t reg got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t pin got %b exp %b", $time, g, e);
    end
  endtask
  task automatic chkr(input int g, input int lo, input int hi);
    n_checks++;
    if (g < lo || g > hi) begin
      failures++;
      $display("mismatch t=%0t count %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // Write-0-only bits keep old ones; free bits take the written value
  function automatic logic [7:0] wr_f(input logic [7:0] o,
                                      input logic [7:0] w);
    return {w[7], o[6] & w[6], w[5], o[4] & w[4], w[3], o[2:0] & w[2:0]};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic [7:0] q;
    host.xfer(1'b1, a, v, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b0, a, 8'h00, q);
    chk8(q, e);
  endtask
  task automatic wait_en();
    int k = 0;
    while (sample_en !== 1'b1 && k < 120) begin cyc(1); k++; end
    chk1(sample_en, 1'b1);
  endtask
  // Phase of the oscillator divider is unknown, hence the range
  task automatic chk_release();
    int k = 0;
    while (rst_n !== 1'b1 && k < 5 * REL * OSC) begin cyc(1); k++; end
    chkr(k, (REL - 1) * OSC, REL * OSC + 10);
  endtask
  task automatic final_report();
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well above the 8000 to 9000 cycles the run needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin failures++; final_report(); end
  end

  // =====================================================================
  // Main sequence
  initial begin
    void'($urandom(61034));
    cyc(10);
    sys_rst_i = 1'b0;
    rd_chk(4'hF, 8'h10);
    rd_chk(4'hE, 8'h00);
    rd_chk(4'h3, 8'h00);
    psc = 8'h10;
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      wr(4'hF, d);
      psc = wr_f(psc, d);
      rd_chk(4'hF, psc);
      chk1(thr_sel, psc[7]);
    end
    cyc(1); flag_set_i = 3'h7; cyc(1); flag_set_i = 3'h0;
    psc[2:0] = 3'h7;
    rd_chk(4'hF, psc);
    e7 = 8'($urandom);
    ee = 8'($urandom);
    wr(4'h7, e7);
    wr(4'hE, ee);
    rd_chk(4'h7, e7);
    rd_chk(4'hE, ee);
    cyc(1); por_i = 1'b1; cyc(1); por_i = 1'b0;
    rd_chk(4'hF, {2'b00, psc[5], 5'h10});
    rd_chk(4'h7, 8'h00);
    rd_chk(4'hE, 8'h00);
    chk1(thr_sel, 1'b0);
    wr(4'hF, 8'h20);
    rd_chk(4'hF, 8'h20);
    // Sampling window length, then a low supply inside a window
    wait_en();
    n = 0;
    while (sample_en === 1'b1 && n < 50) begin cyc(1); n++; end
    chkr(n, 10, 10);
    wait_en();
    vdd_low_i = 1'b1; cyc(3); vdd_low_i = 1'b0;
    rd_chk(4'hF, 8'h60);
    n = 0;
    while (sample_en !== 1'b1 && n < 250) begin cyc(1); n++; end
    chkr(n, 250, 250);
    host.clear_vdet(8'h20);
    rd_chk(4'hF, 8'h20);
    wait_en();
    // Oscillator halt caused by a sagging core supply, outside a window
    cyc(12);
    vdd_low_i = 1'b1; osc_run_i = 1'b0; cyc(3);
    rd_chk(4'hF, 8'h40);
    vdd_low_i = 1'b0; osc_run_i = 1'b1;
    wr(4'hF, 8'h20);
    // Main supply drop and return
    vcc_low_i = 1'b1; cyc(1);
    chk1(main_sw, 1'b0);
    chk1(backup_sw, 1'b1);
    chk1(rst_n, 1'b0);
    cyc(5 + $urandom % 20);
    vcc_low_i = 1'b0; cyc(1);
    chk1(main_sw, 1'b1);
    chk1(backup_sw, 1'b0);
    chk_release();
    // Return while halted: delay counts from oscillation start
    vcc_low_i = 1'b1; osc_run_i = 1'b0; cyc(3); vcc_low_i = 1'b0;
    cyc(2000);
    chk1(rst_n, 1'b0);
    osc_run_i = 1'b1;
    chk_release();
    final_report();
  end
endmodule // tb_power_osc_supply_monitor

`default_nettype wire
